// ==== src/dtm_cfg.svh ====
`ifndef DTM_CFG_SVH
`define DTM_CFG_SVH

`define DTM_CLK_HZ        100000000
`define DTM_TEMP_W        8
`define DTM_TMR_W         40
`define DTM_MCNT_W        16
`define DTM_Q_DEPTH       8
`define DTM_Q_AW          3

// polling periods in minutes, and the log save interval
`define DTM_PER_LOW_MIN   5
`define DTM_PER_MID_MIN   15
`define DTM_PER_HIGH_MIN  10
`define DTM_SAVE_LO_MIN   26
`define DTM_SAVE_HI_MIN   35
`define DTM_SAVE_MIN      30

`define DTM_PER_LOW_CYC   (64'(`DTM_PER_LOW_MIN) * 64'd60 * 64'(`DTM_CLK_HZ))
`define DTM_PER_MID_CYC   (64'(`DTM_PER_MID_MIN) * 64'd60 * 64'(`DTM_CLK_HZ))
`define DTM_PER_HIGH_CYC  (64'(`DTM_PER_HIGH_MIN) * 64'd60 * 64'(`DTM_CLK_HZ))
`define DTM_SAVE_CYC      (64'(`DTM_SAVE_MIN) * 64'd60 * 64'(`DTM_CLK_HZ))

// measurement window in microseconds: least rounds up, longest rounds down
`define DTM_MEAS_MIN_US   200
`define DTM_MEAS_MAX_US   440
`define DTM_MEAS_MIN_CYC  ((64'(`DTM_MEAS_MIN_US) * 64'(`DTM_CLK_HZ) + 64'd999999) / 64'd1000000)
`define DTM_MEAS_MAX_CYC  ((64'(`DTM_MEAS_MAX_US) * 64'(`DTM_CLK_HZ)) / 64'd1000000)

// thresholds in degrees celsius
`define DTM_THR1_LO       8'h06
`define DTM_THR1_HI       8'h41
`define DTM_THR1_DEF      8'h36
`define DTM_THR2          8'h41
`define DTM_HYST          8'h05
`define DTM_ZERO          8'h00

`endif

// ==== src/dtm_pkg.sv ====
`include "dtm_cfg.svh"

package dtm_pkg;

	typedef logic [`DTM_TEMP_W-1:0] dtm_temp_t;
	typedef logic [`DTM_TMR_W-1:0]  dtm_tmr_t;
	typedef logic [`DTM_MCNT_W-1:0] dtm_mcnt_t;
	typedef logic [`DTM_Q_AW-1:0]   dtm_qaddr_t;

	typedef enum logic [1:0] {
		BAND_LOW,
		BAND_MID,
		BAND_HIGH
	} dtm_band_t;

	typedef enum logic {
		MS_IDLE,
		MS_WAIT
	} dtm_meas_t;

	typedef struct packed {
		dtm_band_t band;
		logic      failure_prediction_event;
		logic      meas_fault;
		dtm_temp_t temp;
	} dtm_status_t;

	typedef struct packed {
		logic      valid;
		dtm_temp_t temp;
	} dtm_rec_t;

endpackage : dtm_pkg

// ==== src/dtm_log_mem.sv ====
`timescale 1ns/10ps
`default_nettype none

module dtm_log_mem
	import dtm_pkg::*;
(
	// clock
	input  wire logic       mclk,
	// write side
	input  wire logic       wr_en,
	input  wire dtm_qaddr_t wr_addr,
	input  wire dtm_temp_t  wr_data,
	// read side
	input  wire logic       rd_en,
	input  wire dtm_qaddr_t rd_addr,
	output var  dtm_temp_t  rd_data
);

	dtm_temp_t mem [`DTM_Q_DEPTH];

	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule : dtm_log_mem

`default_nettype wire

// ==== src/dtm_monitor.sv ====
// Overview of operation
// - measure once right after reset release
// - repoll every 5, 15 or 10 minutes by band
// - negative readings are recorded as zero
// - no log below threshold one; errors get temperature
// - threshold one from host byte 6..65
// - zero or out-of-range byte gives 54
// - above threshold one: flag event, queue log unless the queue is full
// - warn host only above threshold one
// - leave band only 5 degrees below trigger
// - measurement lasts 200 to 440 us
// - logged values go out with periodic save
// - periodic save every 26 to 35 minutes
`timescale 1ns/10ps
`default_nettype none

module dtm_monitor
	import dtm_pkg::*;
#(
	parameter dtm_tmr_t  PER_LOW_CYC  = dtm_tmr_t'(`DTM_PER_LOW_CYC),
	parameter dtm_tmr_t  PER_MID_CYC  = dtm_tmr_t'(`DTM_PER_MID_CYC),
	parameter dtm_tmr_t  PER_HIGH_CYC = dtm_tmr_t'(`DTM_PER_HIGH_CYC),
	parameter dtm_tmr_t  SAVE_CYC     = dtm_tmr_t'(`DTM_SAVE_CYC),
	parameter dtm_mcnt_t MEAS_MIN_CYC = dtm_mcnt_t'(`DTM_MEAS_MIN_CYC),
	parameter dtm_mcnt_t MEAS_MAX_CYC = dtm_mcnt_t'(`DTM_MEAS_MAX_CYC)
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// sensor pins
	output var  logic        sense_start,
	input  wire logic        sense_done,
	input  wire logic [7:0]  sense_data,
	// host configuration and notification
	input  wire dtm_temp_t   thr_cfg,
	input  wire logic        warn_enable,
	input  wire logic        event_clear,
	output var  logic        host_warning,
	output var  dtm_status_t status,
	// error record request from the drive logic
	input  wire logic        err_req,
	output var  dtm_rec_t    err_rec,
	// periodic log save
	output var  dtm_rec_t    log_wr,
	output var  logic        log_save
);

	////////////////////////////////////////////////////////////////////////////////
	// threshold selection

	function automatic logic thr_in_range(input dtm_temp_t v);
		return (v >= `DTM_THR1_LO) && (v <= `DTM_THR1_HI);
	endfunction : thr_in_range

	wire logic      cfg_ok    = thr_in_range(thr_cfg);
	wire dtm_temp_t thr1      = cfg_ok ? thr_cfg : `DTM_THR1_DEF;
	wire dtm_temp_t thr1_exit = thr1 - `DTM_HYST;
	wire dtm_temp_t thr2_exit = `DTM_THR2 - `DTM_HYST;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; data is held by the sensor while done is high

	logic       done_s1, done_s2;
	logic [7:0] data_s1, data_s2;

	always_ff @(posedge mclk) begin
		done_s1 <= sense_done;
		done_s2 <= done_s1;
		data_s1 <= sense_data;
		data_s2 <= data_s1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// measurement sequencing

	dtm_meas_t mstate;
	dtm_mcnt_t meas_cnt;
	dtm_tmr_t  per_tmr;
	dtm_band_t band;
	dtm_temp_t last_temp;
	logic      event_flag;
	logic      fault;

	wire logic      start_now = (mstate == MS_IDLE) && (per_tmr == '0);
	wire logic      take      = (mstate == MS_WAIT) && done_s2
		&& (meas_cnt >= MEAS_MIN_CYC);
	wire logic      tmo       = (mstate == MS_WAIT) && !take
		&& (meas_cnt >= MEAS_MAX_CYC);
	wire logic      res_neg   = data_s2[7];
	wire dtm_temp_t temp_c    = res_neg ? `DTM_ZERO : data_s2;
	wire logic      over1     = temp_c > thr1;
	wire logic      over2     = temp_c > `DTM_THR2;

	dtm_band_t next_band;
	always_comb begin
		next_band = band;
		unique case (band)
			BAND_LOW: begin
				if (over2)
					next_band = BAND_HIGH;
				else if (over1)
					next_band = BAND_MID;
			end
			BAND_MID: begin
				if (over2)
					next_band = BAND_HIGH;
				else if (temp_c < thr1_exit)
					next_band = BAND_LOW;
			end
			BAND_HIGH: begin
				if (temp_c < thr2_exit)
					next_band = (temp_c < thr1_exit) ? BAND_LOW : BAND_MID;
			end
			default: next_band = BAND_LOW;
		endcase
	end

	wire dtm_band_t per_band = take ? next_band : band;
	wire dtm_tmr_t  next_per = (per_band == BAND_HIGH) ? PER_HIGH_CYC :
		(per_band == BAND_MID) ? PER_MID_CYC : PER_LOW_CYC;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mstate   <= MS_IDLE;
			meas_cnt <= '0;
			per_tmr  <= '0;
		end else begin
			unique case (mstate)
				MS_IDLE: begin
					if (start_now)
						mstate <= MS_WAIT;
					else
						per_tmr <= per_tmr - dtm_tmr_t'(1);
					meas_cnt <= '0;
				end
				MS_WAIT: begin
					meas_cnt <= meas_cnt + dtm_mcnt_t'(1);
					if (take || tmo) begin
						mstate  <= MS_IDLE;
						per_tmr <= next_per;
					end
				end
			endcase
		end
	end

	// the band only moves on a completed reading; a timed out one keeps it
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			band      <= BAND_LOW;
			last_temp <= `DTM_ZERO;
			event_flag <= 1'b0;
			fault     <= 1'b0;
		end else begin
			if (take) begin
				band      <= next_band;
				last_temp <= temp_c;
			end
			// a new event in the clearing cycle wins
			event_flag <= (take && over1) || (event_flag && !event_clear);
			fault      <= tmo || (fault && !event_clear);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// host-facing outputs

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sense_start  <= 1'b0;
			host_warning <= 1'b0;
			err_rec      <= '0;
		end else begin
			sense_start  <= start_now;
			host_warning <= take && over1 && warn_enable;
			err_rec      <= '{valid: err_req, temp: take ? temp_c : last_temp};
		end
	end

	assign status = '{band: band, failure_prediction_event: event_flag,
		meas_fault: fault, temp: last_temp};

	////////////////////////////////////////////////////////////////////////////////
	// log queue; entries wait here until the periodic save drains them

	dtm_qaddr_t wr_ptr, rd_ptr;
	logic [`DTM_Q_AW:0] q_cnt;
	dtm_tmr_t   save_tmr;
	logic       draining;
	logic       rd_vld;
	dtm_temp_t  rd_data;

	// when full the newest reading is dropped; older history is kept
	wire logic q_wr    = take && over1 && (q_cnt != (`DTM_Q_AW+1)'(`DTM_Q_DEPTH));
	wire logic q_rd    = draining && (q_cnt != '0);
	wire logic save_go = (save_tmr == '0) && !draining;

	dtm_log_mem u_mem (
		.mclk    (mclk),
		.wr_en   (q_wr),
		.wr_addr (wr_ptr),
		.wr_data (temp_c),
		.rd_en   (q_rd),
		.rd_addr (rd_ptr),
		.rd_data (rd_data)
	);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			q_cnt    <= '0;
			save_tmr <= SAVE_CYC;
			draining <= 1'b0;
			rd_vld   <= 1'b0;
			log_wr   <= '0;
			log_save <= 1'b0;
		end else begin
			wr_ptr   <= wr_ptr + dtm_qaddr_t'(q_wr);
			rd_ptr   <= rd_ptr + dtm_qaddr_t'(q_rd);
			q_cnt    <= q_cnt + (`DTM_Q_AW+1)'(q_wr) - (`DTM_Q_AW+1)'(q_rd);
			save_tmr <= save_go ? SAVE_CYC : (draining ? save_tmr : save_tmr - dtm_tmr_t'(1));
			rd_vld   <= q_rd;
			log_wr   <= '{valid: rd_vld, temp: rd_vld ? rd_data : `DTM_ZERO};
			log_save <= draining && !q_rd && !rd_vld;
			if (save_go)
				draining <= 1'b1;
			else if (!q_rd && !rd_vld)
				draining <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_init_start: assert property ($rose(rst_n) |-> ##[0:2] sense_start)
		else $error("no measurement after reset");
	a_period_load: assert property (take |=> per_tmr ==
		((band == BAND_HIGH) ? PER_HIGH_CYC : (band == BAND_MID) ? PER_MID_CYC : PER_LOW_CYC))
		else $error("poll period does not match band");
	a_clamp_zero: assert property (take && res_neg |=> status.temp == `DTM_ZERO)
		else $error("negative reading not clamped");
	a_log_above: assert property (take && temp_c <= thr1 |=> q_cnt <= $past(q_cnt))
		else $error("reading logged at or below threshold one");
	a_err_temp: assert property (err_req && !take |=> err_rec.valid && err_rec.temp == last_temp)
		else $error("error record lacks temperature");
	a_thr_pick: assert property (thr_cfg >= `DTM_THR1_LO && thr_cfg <= `DTM_THR1_HI
		|-> thr1 == thr_cfg)
		else $error("threshold selection wrong");
	a_thr_default: assert property (thr_cfg < `DTM_THR1_LO || thr_cfg > `DTM_THR1_HI
		|-> thr1 == `DTM_THR1_DEF)
		else $error("zero or out of range byte did not select default");
	a_event_set: assert property (take && over1 |=> status.failure_prediction_event)
		else $error("event flag not set");
	a_warn_only: assert property (host_warning |-> $past(take) && $past(over1) && $past(warn_enable))
		else $error("warning without exceeding threshold");
	a_hyst_high: assert property (band == BAND_HIGH && take && temp_c >= thr2_exit
		|=> band == BAND_HIGH)
		else $error("upper band left inside hysteresis");
	a_meas_window: assert property (mstate == MS_WAIT && meas_cnt < MEAS_MIN_CYC
		|=> mstate == MS_WAIT)
		else $error("measurement ended before shortest time");
	a_meas_bound: assert property (mstate == MS_WAIT |-> meas_cnt <= MEAS_MAX_CYC)
		else $error("measurement ran past longest time");
	a_save_drain: assert property (log_wr.valid |-> draining || $past(draining, 2))
		else $error("log written outside save");
	a_save_bound: assert property (save_tmr <= SAVE_CYC)
		else $error("save interval out of range");

	c_high_band: cover property (band == BAND_MID ##1 band == BAND_HIGH);
	c_event: cover property (take && over1 && warn_enable);
	c_save: cover property (log_wr.valid ##[1:4] log_save);
	c_timeout: cover property (tmo);

endmodule : dtm_monitor

`default_nettype wire

// ==== sim/dtm_sensor_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module dtm_sensor_model (
	// clock
	input  wire logic       mclk,
	// bench control
	input  wire logic [7:0] temp,
	input  wire logic [4:0] dly,
	input  wire logic       mute,
	// sensor pins
	input  wire logic       sense_start,
	output var  logic       sense_done,
	output var  logic [7:0] sense_data
);
	int         cnt = -1;
	logic [7:0] last = 8'h00;
	initial sense_done = 1'b0;
	always @(posedge mclk) begin
		if (sense_start) begin
			sense_done <= 1'b0;
			cnt <= mute ? -1 : int'(dly);
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end else if (cnt == 0) begin
			sense_done <= 1'b1;
			last <= temp;
			cnt <= -1;
		end
	end
	// data is junk outside done so nothing leans on a stale value
	assign sense_data = sense_done ? last : ~last;
endmodule : dtm_sensor_model
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
	import dtm_pkg::*;
	localparam dtm_tmr_t PL = 40'h00c8;
	localparam dtm_tmr_t PM = 40'h0258;
	localparam dtm_tmr_t PH = 40'h0190;
	localparam dtm_tmr_t PS = 40'h0bb8;
	localparam logic [7:0] COR_T [8] = '{8'h46, 8'h3e, 8'h3b, 8'h32, 8'h30, 8'h37, 8'hf6, 8'h36};
	localparam logic [7:0] COR_C [6] = '{8'h00, 8'h05, 8'h06, 8'h41, 8'h42, 8'hff};
	logic        mclk, rst_n, sense_start, sense_done, warn_enable, event_clear;
	logic        err_req, host_warning, log_save, mute;
	logic [7:0]  sense_data, t_raw;
	logic [4:0]  dly;
	dtm_temp_t   thr_cfg, ex_t, q_h, v_push;
	dtm_status_t status;
	dtm_rec_t    err_rec, log_wr;
	dtm_band_t   ex_b;
	dtm_temp_t   lq[$];
	int          n_mismatch = 0, samples_checked = 0, n_warn = 0, n_save = 0;
	int          cyc = 0, t_st = 0, t_sv = 0, t_push = -1;

	dtm_monitor #(.PER_LOW_CYC(PL), .PER_MID_CYC(PM), .PER_HIGH_CYC(PH), .SAVE_CYC(PS),
		.MEAS_MIN_CYC(16'h0004), .MEAS_MAX_CYC(16'h0014)) dut_u (.mclk(mclk), .rst_n(rst_n),
		.sense_start(sense_start), .sense_done(sense_done), .sense_data(sense_data),
		.thr_cfg(thr_cfg), .warn_enable(warn_enable), .event_clear(event_clear),
		.host_warning(host_warning), .status(status), .err_req(err_req),
		.err_rec(err_rec), .log_wr(log_wr), .log_save(log_save));
	dtm_sensor_model sens_u (.mclk(mclk), .temp(t_raw), .dly(dly), .mute(mute),
		.sense_start(sense_start), .sense_done(sense_done), .sense_data(sense_data));

	////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
		samples_checked++;
		if (got !== ex) begin
			n_mismatch++;
			$display("ERROR %s exp %h got %h", nm, ex, got);
		end
	endtask : chk
	task automatic wait_start();
		int n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (sense_start !== 1'b1 && n < 1000);
		if (n >= 1000) begin
			chk("sense_start", 16'h0001, 16'h0000);
			give_verdict();
		end
	endtask : wait_start
	function automatic dtm_temp_t thr1(dtm_temp_t c);
		return (c >= 8'h06 && c <= 8'h41) ? c : 8'h36;
	endfunction : thr1
	// hysteresis: leave high below 60, leave mid below threshold one minus 5
	function automatic dtm_band_t nband(dtm_band_t b, dtm_temp_t t, dtm_temp_t th);
		if (t > 8'h41) return BAND_HIGH;
		if (b == BAND_HIGH && t >= 8'h3c) return BAND_HIGH;
		if (b != BAND_LOW && t >= th - 8'h05) return BAND_MID;
		return (t > th) ? BAND_MID : BAND_LOW;
	endfunction : nband
	function automatic int per(dtm_band_t b);
		return (b == BAND_LOW) ? int'(PL) : (b == BAND_MID) ? int'(PM) : int'(PH);
	endfunction : per

	////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (host_warning === 1'b1) n_warn <= n_warn + 1;
		// queued two edges after the sensor result is taken, before any save can drain it
		if (cyc == t_push && lq.size() < 8) lq.push_back(v_push);
		if (log_wr.valid === 1'b1) begin
			q_h = (lq.size() > 0) ? lq.pop_front() : 8'hxx;
			chk("log_wr", 16'(q_h), 16'(log_wr.temp));
		end
		if (log_save === 1'b1) begin
			chk("save_gap", 1, 16'(cyc - t_sv >= int'(PS) && cyc - t_sv <= int'(PS) + 40));
			chk("save_left", 0, 16'(lq.size()));
			t_sv <= cyc;
			n_save <= n_save + 1;
		end
	end
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		dtm_temp_t  cfg, tc, th;
		logic [7:0] raw;
		logic       we;
		int         d, w0;
		rst_n = 1'b0;
		thr_cfg = 8'h00;
		warn_enable = 1'b0;
		event_clear = 1'b0;
		err_req = 1'b0;
		t_raw = 8'h00;
		dly = 5'h06;
		mute = 1'b0;
		ex_t = 8'h00;
		ex_b = BAND_LOW;
		void'($urandom(32'h0a33));
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		d = cyc;
		for (int i = 0; i < 24; i++) begin
			raw = (i < 8) ? COR_T[i] : 8'($urandom_range(0, 130) - 20);
			cfg = (i < 8) ? 8'h00 : (i % 2 == 0) ? COR_C[(i / 2) % 6] : 8'($urandom_range(0, 80));
			th = thr1(cfg);
			tc = raw[7] ? 8'h00 : raw;
			we = 1'($urandom);
			t_raw <= raw;
			thr_cfg <= cfg;
			warn_enable <= we;
			dly <= 5'($urandom_range(1, 14));
			mute <= (i == 11);
			w0 = n_warn;
			wait_start();
			if (i == 0)
				chk("first_start", 1, 16'(cyc - d <= 3));
			else
				chk("poll_gap", 1, 16'(cyc - t_st >= per(ex_b) && cyc - t_st <= per(ex_b) + 30));
			t_st = cyc;
			v_push = tc;
			t_push = (i != 11 && tc > th) ? cyc + int'(dly) + 6 : -1;
			repeat (30) @(posedge mclk);
			#1;
			if (i != 11) begin
				ex_b = nband(ex_b, tc, th);
				ex_t = tc;
			end
			chk("band", 16'(ex_b), 16'(status.band));
			chk("temp", 16'(ex_t), 16'(status.temp));
			chk("event", 16'(i != 11 && tc > th), 16'(status.failure_prediction_event));
			chk("fault", 16'(i == 11), 16'(status.meas_fault));
			chk("warning", 16'(i != 11 && tc > th && we), 16'(n_warn - w0));
			@(posedge mclk);
			err_req <= 1'b1;
			@(posedge mclk);
			err_req <= 1'b0;
			event_clear <= 1'b1;
			#1;
			chk("err_rec", {7'h00, 1'b1, ex_t}, 16'(err_rec));
			@(posedge mclk);
			event_clear <= 1'b0;
		end
		chk("saves", 1, 16'(n_save > 0));
		give_verdict();
	end
endmodule : tb
`default_nettype wire
